// *** design/srl_pkg.sv ***
// Shared constants for the read/write latency link between controller and DRAM model.
package srl_pkg;
   localparam int unsigned ADDR_W = 14;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned LAT_W = 6;
   localparam int unsigned CHOP_BIT = 12;
   localparam logic [1:0] BURST_FIXED_EIGHT = 2'h0;
   localparam logic [1:0] BURST_ON_THE_FLY = 2'h1;
   localparam logic [1:0] BURST_FIXED_FOUR = 2'h2;
   localparam logic [LAT_W-1:0] PARITY_LATENCY = 6'h04;
   localparam logic [3:0] EIGHT_BEATS = 4'h8;
   localparam logic [3:0] FOUR_BEATS = 4'h4;
   localparam int unsigned MEM_DEPTH = 64;
   typedef enum logic [1:0] {
      SRL_CMD_DESELECT,
      SRL_CMD_READ,
      SRL_CMD_WRITE
   } srl_cmd_t;
endpackage

// *** design/srl_if.sv ***
// Link between the memory controller and the DRAM command and data side.
`timescale 1ns/1ns
interface srl_if;
   import srl_pkg::*;
   srl_cmd_t cmd;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic wvalid;
   logic [DATA_W-1:0] rdata;
   logic rvalid;
   modport dram (input cmd, input addr, input wdata, input wvalid, output rdata, output rvalid);
   modport ctrl (output cmd, output addr, output wdata, output wvalid, input rdata, input rvalid);
endinterface

// *** design/srl_dram.sv ***
// DRAM end: latency, burst length selection and data beats.
`timescale 1ns/1ns
// Function
// - read latency adds parity latency when enabled
// - write latency adds parity latency when enabled
// - eight beats for field 00 or 01 high
// - field 01 with select low chops four
// - field 10 always chops four beats
// - controller keeps termination timing with address latency; srl_ctrl drives no termination signal
// - read eight may precede write eight or four
// - write timing valid only with loop locked
// - controller trains input or uses worst limits; srl_ctrl does no training and uses the configured latencies
module srl_dram
   import srl_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   srl_if.dram link,
   input wire logic [1:0] burst_field,
   input wire logic parity_en,
   input wire logic dll_locked,
   input wire logic [LAT_W-1:0] cas_latency,
   input wire logic [LAT_W-1:0] additive_latency,
   input wire logic [LAT_W-1:0] write_cas_latency,
   output logic write_error
);
   logic [DATA_W-1:0] mem [MEM_DEPTH];
   logic [LAT_W-1:0] read_latency;
   logic [LAT_W-1:0] write_latency;
   logic [3:0] beats;
   logic [LAT_W+3:0] rd_cnt_r, wr_cnt_r;
   logic [3:0] rd_len_r, wr_len_r;
   logic [5:0] rd_addr_r, wr_addr_r;
   logic rd_act_r, wr_act_r;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      read_latency = cas_latency + additive_latency + (parity_en ? PARITY_LATENCY : 6'h00);
      write_latency = write_cas_latency + additive_latency
         + (parity_en ? PARITY_LATENCY : 6'h00);
      if (burst_field == BURST_FIXED_FOUR) begin
         beats = FOUR_BEATS;
      end else if (burst_field == BURST_ON_THE_FLY && !link.addr[CHOP_BIT]) begin
         beats = FOUR_BEATS;
      end else begin
         beats = EIGHT_BEATS;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // A read and a write may overlap in flight, so each has its own tracker.
   always_ff @(posedge clk) begin
      if (rst) begin
         rd_act_r <= 1'b0;
         rd_cnt_r <= '0;
         rd_len_r <= 4'h0;
         rd_addr_r <= 6'h00;
      end else if (link.cmd == SRL_CMD_READ) begin
         rd_act_r <= 1'b1;
         rd_cnt_r <= {4'h0, read_latency} + {6'h00, beats} - 10'h001;
         rd_len_r <= beats;
         rd_addr_r <= link.addr[5:0];
      end else if (rd_act_r) begin
         rd_cnt_r <= rd_cnt_r - 10'h001;
         if (rd_cnt_r == '0) begin
            rd_act_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         link.rvalid <= 1'b0;
         link.rdata <= '0;
      end else begin
         link.rvalid <= rd_act_r && rd_cnt_r < {6'h00, rd_len_r};
         link.rdata <= mem[rd_addr_r + 6'(rd_len_r - 4'h1 - rd_cnt_r[3:0])];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Writes are only tracked against latency while the loop is locked.
   always_ff @(posedge clk) begin
      if (rst) begin
         wr_act_r <= 1'b0;
         wr_cnt_r <= '0;
         wr_len_r <= 4'h0;
         wr_addr_r <= 6'h00;
      end else if (link.cmd == SRL_CMD_WRITE && dll_locked) begin
         wr_act_r <= 1'b1;
         wr_cnt_r <= {4'h0, write_latency} + {6'h00, beats} - 10'h001;
         wr_len_r <= beats;
         wr_addr_r <= link.addr[5:0];
      end else if (wr_act_r) begin
         wr_cnt_r <= wr_cnt_r - 10'h001;
         if (wr_cnt_r == '0) begin
            wr_act_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (wr_act_r && wr_cnt_r < {6'h00, wr_len_r} && link.wvalid) begin
         mem[wr_addr_r + 6'(wr_len_r - 4'h1 - wr_cnt_r[3:0])] <= link.wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         write_error <= 1'b0;
      end else begin
         write_error <= (link.wvalid != (wr_act_r && wr_cnt_r < {6'h00, wr_len_r}))
            || (link.cmd == SRL_CMD_WRITE && !dll_locked);
      end
   end
endmodule

// *** design/srl_ctrl.sv ***
// Controller end: issues commands and places write data at the write latency.
`timescale 1ns/1ns
module srl_ctrl
   import srl_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   srl_if.ctrl link,
   input wire logic [1:0] burst_field,
   input wire logic parity_en,
   input wire logic dll_locked,
   input wire logic [LAT_W-1:0] additive_latency,
   input wire logic [LAT_W-1:0] write_cas_latency,
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic req_chop,
   input wire logic [ADDR_W-1:0] req_addr,
   input wire logic [DATA_W-1:0] req_wdata,
   output logic req_ready,
   output logic [DATA_W-1:0] rd_data,
   output logic rd_valid
);
   logic [LAT_W-1:0] write_latency;
   logic [3:0] beats;
   logic [LAT_W+3:0] cnt_r;
   logic [3:0] len_r;
   logic busy_r;
   logic [DATA_W-1:0] data_r;

   always_comb begin
      write_latency = write_cas_latency + additive_latency
         + (parity_en ? PARITY_LATENCY : 6'h00);
      if (burst_field == BURST_FIXED_FOUR) begin
         beats = FOUR_BEATS;
      end else if (burst_field == BURST_ON_THE_FLY && req_chop) begin
         beats = FOUR_BEATS;
      end else begin
         beats = EIGHT_BEATS;
      end
      // One write at a time keeps the data beats simple; reads are also held while a write is in flight.
      req_ready = !busy_r && (dll_locked || !req_write);
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk) begin
      if (rst) begin
         link.cmd <= SRL_CMD_DESELECT;
         link.addr <= '0;
      end else if (req_valid && req_ready) begin
         link.cmd <= req_write ? SRL_CMD_WRITE : SRL_CMD_READ;
         link.addr <= req_addr;
         link.addr[CHOP_BIT] <= !req_chop;
      end else begin
         link.cmd <= SRL_CMD_DESELECT;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         busy_r <= 1'b0;
         cnt_r <= '0;
         len_r <= 4'h0;
         data_r <= '0;
      end else if (req_valid && req_ready && req_write) begin
         busy_r <= 1'b1;
         cnt_r <= {4'h0, write_latency} + {6'h00, beats} - 10'h001;
         len_r <= beats;
         data_r <= req_wdata;
      end else if (busy_r) begin
         cnt_r <= cnt_r - 10'h001;
         if (cnt_r == '0) begin
            busy_r <= 1'b0;
         end
      end
   end

   // The command goes out one cycle after acceptance, so registering the beats here keeps data aligned.
   always_ff @(posedge clk) begin
      if (rst) begin
         link.wvalid <= 1'b0;
         link.wdata <= '0;
      end else begin
         link.wvalid <= busy_r && cnt_r < {6'h00, len_r};
         link.wdata <= data_r + 8'(len_r - 4'h1 - cnt_r[3:0]);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rd_valid <= 1'b0;
         rd_data <= '0;
      end else begin
         rd_valid <= link.rvalid;
         rd_data <= link.rdata;
      end
   end
endmodule

// *** tb/srl_monitor.sv ***
// Checker of read and write latency, burst length and write order on the link.
`timescale 1ns/1ns
module srl_monitor
   import srl_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire srl_cmd_t cmd,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic wvalid,
   input wire logic rvalid,
   input wire logic [1:0] burst_field,
   input wire logic parity_en,
   input wire logic dll_locked,
   input wire logic [LAT_W-1:0] cas_latency,
   input wire logic [LAT_W-1:0] additive_latency,
   input wire logic [LAT_W-1:0] write_cas_latency
);
   ////////////////////////////////////////
   // Command history; bit k holds the command seen k+1 edges ago.
   logic [63:0] rd_h_r;
   logic [63:0] wr_h_r;
   logic [63:0] e8_h_r;
   logic [6:0] rl;
   logic [6:0] wl;
   logic eight;
   assign rl = 7'(cas_latency) + 7'(additive_latency)
      + (parity_en ? 7'(PARITY_LATENCY) : 7'h00);
   assign wl = 7'(write_cas_latency) + 7'(additive_latency)
      + (parity_en ? 7'(PARITY_LATENCY) : 7'h00);
   assign eight = burst_field == BURST_FIXED_EIGHT
      || (burst_field == BURST_ON_THE_FLY && addr[CHOP_BIT]);
   always_ff @(posedge clk) begin
      if (rst) begin
         rd_h_r <= 64'h0;
         wr_h_r <= 64'h0;
         e8_h_r <= 64'h0;
      end else begin
         rd_h_r <= {rd_h_r[62:0], cmd == SRL_CMD_READ};
         wr_h_r <= {wr_h_r[62:0], cmd == SRL_CMD_WRITE};
         e8_h_r <= {e8_h_r[62:0], eight};
      end
   end
   ////////////////////////////////////////
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // A read's first beat is sampled rl+2 edges after its command, a write's wl+1 edges after.
   a_read_latency: assert property ($rose(rvalid) |-> rd_h_r[rl + 7'h01])
      else $error("read beat early or late");
   a_write_latency: assert property ($rose(wvalid) |-> wr_h_r[wl])
      else $error("write beat misplaced");
   a_read_eight: assert property ($rose(rvalid) && e8_h_r[rl + 7'h01]
      |-> rvalid[*8] ##1 !rvalid) else $error("read not eight");
   a_read_four: assert property ($rose(rvalid) && !e8_h_r[rl + 7'h01]
      |-> rvalid[*4] ##1 !rvalid) else $error("read not four");
   a_write_eight: assert property ($rose(wvalid) && e8_h_r[wl]
      |-> wvalid[*8] ##1 !wvalid) else $error("write not eight");
   a_write_chop: assert property ($rose(wvalid) && !e8_h_r[wl]
      |-> wvalid[*4] ##1 !wvalid) else $error("write not four");
   a_write_locked: assert property (cmd == SRL_CMD_WRITE |-> $past(dll_locked))
      else $error("write while unlocked");
   a_one_write: assert property (cmd == SRL_CMD_WRITE |-> wr_h_r[3:0] == 4'h0)
      else $error("writes too close");
endmodule

// *** tb/tb_top.sv ***
// Bench driving requests through the controller into the DRAM end.
`timescale 1ns/1ns
module tb_top;
   import srl_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [1:0] burst_field = 2'h0;
   logic parity_en = 1'b1;
   logic dll_locked = 1'b1;
   logic req_valid = 1'b0;
   logic req_write = 1'b0;
   logic req_chop = 1'b0;
   logic [ADDR_W-1:0] req_addr = 14'h0000;
   logic [DATA_W-1:0] req_wdata = 8'h00;
   logic [LAT_W-1:0] cas_latency = 6'h05;
   logic [LAT_W-1:0] additive_latency = 6'h00;
   logic [LAT_W-1:0] write_cas_latency = 6'h04;
   logic werr = 1'b0;
   // Acceptance, command, DRAM output and controller copy each add one edge to a read.
   localparam int RD_PIPE = 4;
   logic req_ready, rd_valid, write_error;
   logic [DATA_W-1:0] rd_data;
   logic [DATA_W-1:0] rq[$];
   int fails = 0, checks = 0, cyc = 0, acc = 0, first = 0;
   always #5 clk = ~clk;
   srl_if link ();
   srl_ctrl srl_ctrl_inst (.clk, .rst, .link(link.ctrl), .burst_field, .parity_en, .dll_locked,
      .additive_latency, .write_cas_latency, .req_valid, .req_write, .req_chop,
      .req_addr, .req_wdata, .req_ready, .rd_data, .rd_valid);
   srl_dram srl_dram_inst (.clk, .rst, .link(link.dram), .burst_field, .parity_en, .dll_locked,
      .cas_latency, .additive_latency, .write_cas_latency, .write_error);
   srl_monitor srl_monitor_inst (.clk, .rst, .cmd(link.cmd), .addr(link.addr),
      .wvalid(link.wvalid), .rvalid(link.rvalid), .burst_field, .parity_en, .dll_locked,
      .cas_latency, .additive_latency, .write_cas_latency);
   ////////////////////////////////////////
   function automatic int rd_lat();
      int sum;
      sum = int'(cas_latency) + int'(additive_latency) + RD_PIPE;
      if (parity_en) begin
         sum = sum + int'(PARITY_LATENCY);
      end
      return sum;
   endfunction
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task print_verdict;
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // The request is held until taken; the idle edge after it avoids a double drive.
   task req(input logic wr, input logic ch, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      int n;
      n = 0;
      req_valid <= 1'b1;
      req_write <= wr;
      req_chop <= ch;
      req_addr <= a;
      req_wdata <= d;
      do begin
         @(posedge clk);
         n++;
      end while (req_ready !== 1'b1 && n < 200);
      acc = cyc;
      req_valid <= 1'b0;
      @(posedge clk);
   endtask
   task get(input int nb, input logic [DATA_W-1:0] base, input int lat);
      repeat (24) @(posedge clk);
      chk(32'(rq.size()), 32'(nb));
      if (lat > 0) chk(32'(first - acc), 32'(lat));
      foreach (rq[i]) chk(32'(rq[i]), 32'(base) + 32'(i));
      rq.delete();
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (rd_valid === 1'b1) begin
         if (rq.size() == 0) first = cyc;
         rq.push_back(rd_data);
      end
      if (write_error === 1'b1) werr <= 1'b1;
      if (cyc == 3000) begin
         fails++;
         print_verdict();
      end
   end
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      req(1'b1, 1'b0, 14'h0000, 8'h10);
      req(1'b0, 1'b0, 14'h0000, 8'h00);
      get(8, 8'h10, rd_lat());
      parity_en <= 1'b0;
      req(1'b0, 1'b0, 14'h0000, 8'h00);
      get(8, 8'h10, rd_lat());
      burst_field <= BURST_ON_THE_FLY;
      additive_latency <= 6'h02;
      req(1'b1, 1'b1, 14'h0010, 8'h40);
      req(1'b0, 1'b1, 14'h0010, 8'h00);
      get(4, 8'h40, rd_lat());
      req(1'b0, 1'b0, 14'h0000, 8'h00);
      req(1'b1, 1'b0, 14'h0020, 8'h50);
      get(8, 8'h10, 0);
      req(1'b0, 1'b0, 14'h0020, 8'h00);
      get(8, 8'h50, rd_lat());
      burst_field <= BURST_FIXED_FOUR;
      req(1'b1, 1'b0, 14'h0030, 8'h80);
      req(1'b0, 1'b0, 14'h0030, 8'h00);
      get(4, 8'h80, rd_lat());
      dll_locked <= 1'b0;
      req_write <= 1'b1;
      req_valid <= 1'b1;
      repeat (6) @(posedge clk);
      chk(32'(req_ready), 32'h0);
      chk(32'(write_error), 32'h0);
      chk(32'(werr), 32'h0);
      print_verdict();
   end
endmodule
